//--- hw/clk_ctl_pkg.sv
// shared constants, register map and carrier types of the high-speed clock control
package clk_ctl_pkg;
    // timing at a 50 ns clock
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned SUSP_MIN_NS    = 4060;   // 4.06 us least cpu stop
    localparam int unsigned SUSP_MAX_NS    = 16120;  // 16.12 us longest cpu stop
    localparam int unsigned XTAL_SUSP_CYC  = (SUSP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned XTAL_SUSP_MAX  = SUSP_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned EXT_SUSP_EDGES = 160;    // external clock periods of cpu stop

    // register byte offsets
    localparam logic [7:0] OFS_PIN_CTRL  = 8'h00;    // osc_pin_ctrl_reg
    localparam logic [7:0] OFS_OSC_CTRL  = 8'h04;    // main_osc_ctrl_reg
    localparam logic [7:0] OFS_MAIN_MODE = 8'h08;    // main_clk_mode_reg
    localparam logic [7:0] OFS_PROC_CLK  = 8'h0c;    // proc_clk_ctrl_reg
    localparam logic [7:0] OFS_PORT      = 8'h10;    // port data of the shared pins

    // field positions
    localparam int unsigned BIT_GAIN       = 0;
    localparam int unsigned BIT_PIN_MODE   = 6;
    localparam int unsigned BIT_EXT_SEL    = 7;
    localparam int unsigned BIT_HS_STOP    = 7;
    localparam int unsigned BIT_MAIN_SEL   = 0;
    localparam int unsigned BIT_MAIN_ON_HS = 1;
    localparam int unsigned BIT_MAIN_SRC   = 2;
    localparam int unsigned DIV_LSB        = 0;
    localparam int unsigned BIT_CPU_SRC    = 4;
    localparam int unsigned BIT_CPU_ON_SUB = 5;
    localparam int unsigned PORT_OUT_LSB   = 0;
    localparam int unsigned PORT_DIR_LSB   = 2;
    localparam int unsigned PORT_IN_LSB    = 4;

    // reset values and limits
    localparam logic       RST_HS_STOP = 1'b1;
    localparam logic [2:0] RST_DIV     = 3'h1;
    localparam logic [2:0] DIV_MAX     = 3'h4;
    localparam logic [8:0] SUSP_LOAD_X = 9'(XTAL_SUSP_CYC);
    localparam logic [8:0] SUSP_LOAD_E = 9'(EXT_SUSP_EDGES);

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SUSP_IDLE = 3'b001,
        SUSP_XTAL = 3'b010,
        SUSP_EXT  = 3'b100
    } susp_e;

    typedef struct packed {
        logic       gain;
        logic       ext_sel;
        logic       pin_mode;
        logic       hs_stop;
        logic       main_src;
        logic       main_sel;
        logic       cpu_src;
        logic [2:0] div;
        logic [1:0] port_out;
        logic [1:0] port_dir;
    } clk_cfg_s;

    // terminal count of the cpu divider for a divide code
    function automatic logic [3:0] div_limit(input logic [2:0] code);
        div_limit = 4'((5'h1 << code) - 5'h1);
    endfunction
endpackage

//--- hw/clk_tick_divider.sv
// divides a clock-enable pulse train by a power of two
module clk_tick_divider (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick_in,
    input  wire logic       hold,
    input  wire logic [2:0] div_code,
    output logic            tick_out
);
    logic [3:0] cnt_ff;
    logic       tick_ff;

    // a held tick is swallowed, so the cpu sees no edge during a stop
    wire        pass  = tick_in & ~hold;
    wire [3:0] limit  = clk_ctl_pkg::div_limit(div_code);
    wire        wrap  = pass & (cnt_ff >= limit);

    // counter restarts on wrap; a shrinking code wraps at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff  <= 4'h0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= wrap;
            if (pass)
                cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
        end
    end

    assign tick_out = tick_ff;

    property p_div_one;
        @(posedge aclk) disable iff (!aresetn)
        (div_code == 3'h0 && pass) |=> tick_ff;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one dropped a tick");

    property p_div_held;
        @(posedge aclk) disable iff (!aresetn)
        hold |=> !tick_ff;
    endproperty
    a_div_held: assert property (p_div_held) else $error("tick passed while held");
endmodule // clk_tick_divider

//--- hw/hs_clk_ctrl.sv
// high-speed system clock control: pin modes, start/stop, clock selection, axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
module hs_clk_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              stop_exec,
    input  wire logic              standby_exit,
    input  wire logic              sub_clk_tick,
    input  wire logic              pin_a_in,
    output logic                   pin_a_out,
    output logic                   pin_a_oe,
    input  wire logic              pin_b_in,
    output logic                   pin_b_out,
    output logic                   pin_b_oe,
    output logic                   osc_amp_en,
    output logic                   osc_high_gain,
    output logic                   main_clk_tick,
    output logic                   periph_clk_tick,
    output logic                   cpu_clk_tick,
    output logic                   cpu_hold,
    output logic                   standby
);
    clk_ctl_pkg::clk_cfg_s cfg_ff, nxt_cfg;
    clk_ctl_pkg::susp_e    state_ff, nxt_state;
    logic [8:0]  cnt_ff, nxt_cnt;
    logic        gain_lock_ff, standby_ff, hold_ff;
    logic [2:0]  a_sync_ff, b_sync_ff;
    logic        aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
    logic        arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, w_data_ff;
    logic [3:0]  w_strb_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic        main_tick_ff, periph_tick_ff, amp_ff;
    logic        a_out_ff, a_oe_ff, b_out_ff, b_oe_ff;

    // pin samples: stage 0 only feeds stage 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_sync_ff <= 3'h0;
            b_sync_ff <= 3'h0;
        end else begin
            a_sync_ff <= {a_sync_ff[1:0], pin_a_in};
            b_sync_ff <= {b_sync_ff[1:0], pin_b_in};
        end
    end

    // mode decode; resonator sampled at the system rate is only a coarse model
    wire xtal_mode = cfg_ff.pin_mode & ~cfg_ff.ext_sel;
    wire ext_mode  = cfg_ff.pin_mode & cfg_ff.ext_sel;
    wire a_rise    = a_sync_ff[1] & ~a_sync_ff[2];
    wire b_rise    = b_sync_ff[1] & ~b_sync_ff[2];
    wire hs_run    = ~cfg_ff.hs_stop & ~standby_ff;
    wire fin_tick  = hs_run & ((xtal_mode & a_rise) | (ext_mode & b_rise));
    wire main_hs   = cfg_ff.main_src & cfg_ff.main_sel;
    wire main_tick = main_hs ? fin_tick : 1'b1;
    wire per_tick  = cfg_ff.main_src ? fin_tick : 1'b1;
    wire cpu_in    = cfg_ff.cpu_src ? sub_clk_tick : main_tick;
    wire [2:0] cpu_code = cfg_ff.cpu_src ? 3'h0 : cfg_ff.div;

    // axi write path: address and data land in either order
    wire aw_hs   = awvalid & awready_ff;
    wire w_hs    = wvalid & wready_ff;
    wire do_wr   = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire b_done  = bvalid_ff & bready;
    wire [7:0] wa = 8'(aw_addr_ff);
    wire wr_hit  = wa == clk_ctl_pkg::OFS_PIN_CTRL || wa == clk_ctl_pkg::OFS_OSC_CTRL ||
                   wa == clk_ctl_pkg::OFS_MAIN_MODE || wa == clk_ctl_pkg::OFS_PROC_CLK ||
                   wa == clk_ctl_pkg::OFS_PORT;
    wire wr_en   = do_wr & wr_hit & w_strb_ff[0];
    wire [7:0] wb = w_data_ff[7:0];
    wire new_gain  = wb[clk_ctl_pkg::BIT_GAIN];
    wire gain_chg  = wr_en & (wa == clk_ctl_pkg::OFS_PIN_CTRL) & ~gain_lock_ff
                     & (new_gain != cfg_ff.gain);
    wire gain_rise = gain_chg & new_gain;
    wire [2:0] new_div = wb[clk_ctl_pkg::DIV_LSB +: 3];

    // register updates; a prohibited divide code keeps the old ratio
    always_comb begin
        nxt_cfg = cfg_ff;
        if (gain_chg)
            nxt_cfg.gain = new_gain;
        if (wr_en && wa == clk_ctl_pkg::OFS_PIN_CTRL) begin
            nxt_cfg.pin_mode = wb[clk_ctl_pkg::BIT_PIN_MODE];
            nxt_cfg.ext_sel  = wb[clk_ctl_pkg::BIT_EXT_SEL];
        end
        if (wr_en && wa == clk_ctl_pkg::OFS_OSC_CTRL)
            nxt_cfg.hs_stop = wb[clk_ctl_pkg::BIT_HS_STOP];
        if (wr_en && wa == clk_ctl_pkg::OFS_MAIN_MODE) begin
            nxt_cfg.main_src = wb[clk_ctl_pkg::BIT_MAIN_SRC];
            nxt_cfg.main_sel = wb[clk_ctl_pkg::BIT_MAIN_SEL];
        end
        if (wr_en && wa == clk_ctl_pkg::OFS_PROC_CLK) begin
            nxt_cfg.cpu_src = wb[clk_ctl_pkg::BIT_CPU_SRC];
            if (new_div <= clk_ctl_pkg::DIV_MAX)
                nxt_cfg.div = new_div;
        end
        if (wr_en && wa == clk_ctl_pkg::OFS_PORT) begin
            nxt_cfg.port_out = wb[clk_ctl_pkg::PORT_OUT_LSB +: 2];
            nxt_cfg.port_dir = wb[clk_ctl_pkg::PORT_DIR_LSB +: 2];
        end
    end

    // cpu stop after a gain raise, timed per pin mode
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            clk_ctl_pkg::SUSP_IDLE: begin
                if (gain_rise && ext_mode) begin
                    nxt_state = clk_ctl_pkg::SUSP_EXT;
                    nxt_cnt   = clk_ctl_pkg::SUSP_LOAD_E;
                end else if (gain_rise && xtal_mode) begin
                    nxt_state = clk_ctl_pkg::SUSP_XTAL;
                    nxt_cnt   = clk_ctl_pkg::SUSP_LOAD_X;
                end
            end
            clk_ctl_pkg::SUSP_XTAL: begin
                nxt_cnt = cnt_ff - 9'h1;
                if (cnt_ff == 9'h1)
                    nxt_state = clk_ctl_pkg::SUSP_IDLE;
            end
            clk_ctl_pkg::SUSP_EXT: begin
                if (b_rise) begin
                    nxt_cnt = cnt_ff - 9'h1;
                    if (cnt_ff == 9'h1)
                        nxt_state = clk_ctl_pkg::SUSP_IDLE;
                end
            end
            default: begin
                nxt_state = clk_ctl_pkg::SUSP_IDLE;
                nxt_cnt   = 9'h0;
            end
        endcase
    end

    // configuration, standby and stop state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff        <= '0;
            cfg_ff.hs_stop <= clk_ctl_pkg::RST_HS_STOP;
            cfg_ff.div    <= clk_ctl_pkg::RST_DIV;
            gain_lock_ff  <= 1'b0;
            standby_ff    <= 1'b0;
            state_ff      <= clk_ctl_pkg::SUSP_IDLE;
            cnt_ff        <= 9'h0;
            hold_ff       <= 1'b0;
        end else begin
            cfg_ff       <= nxt_cfg;
            gain_lock_ff <= gain_lock_ff | gain_chg;
            standby_ff   <= stop_exec | (standby_ff & ~standby_exit);
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            hold_ff      <= nxt_state != clk_ctl_pkg::SUSP_IDLE;
        end
    end

    // registered clock enables and pin drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_tick_ff   <= 1'b0;
            periph_tick_ff <= 1'b0;
            amp_ff         <= 1'b0;
            {a_out_ff, a_oe_ff, b_out_ff, b_oe_ff} <= 4'h0;
        end else begin
            main_tick_ff   <= main_tick;
            periph_tick_ff <= per_tick;
            amp_ff         <= xtal_mode & hs_run;
            a_out_ff       <= cfg_ff.port_out[0];
            a_oe_ff        <= (~cfg_ff.pin_mode | ext_mode) & cfg_ff.port_dir[0];
            b_out_ff       <= cfg_ff.port_out[1];
            b_oe_ff        <= ~cfg_ff.pin_mode & cfg_ff.port_dir[1];
        end
    end

    clk_tick_divider u_cpu_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (cpu_in),
        .hold     (hold_ff | standby_ff),
        .div_code (cpu_code),
        .tick_out (cpu_clk_tick)
    );

    // read decode; status bits show the live selection
    wire [7:0] ra = 8'(araddr);
    wire rd_hit = ra == clk_ctl_pkg::OFS_PIN_CTRL || ra == clk_ctl_pkg::OFS_OSC_CTRL ||
                  ra == clk_ctl_pkg::OFS_MAIN_MODE || ra == clk_ctl_pkg::OFS_PROC_CLK ||
                  ra == clk_ctl_pkg::OFS_PORT;
    wire [31:0] rd_pin  = (32'(cfg_ff.gain) << clk_ctl_pkg::BIT_GAIN) |
                          (32'(cfg_ff.pin_mode) << clk_ctl_pkg::BIT_PIN_MODE) |
                          (32'(cfg_ff.ext_sel) << clk_ctl_pkg::BIT_EXT_SEL);
    wire [31:0] rd_mode = (32'(cfg_ff.main_sel) << clk_ctl_pkg::BIT_MAIN_SEL) |
                          (32'(main_hs) << clk_ctl_pkg::BIT_MAIN_ON_HS) |
                          (32'(cfg_ff.main_src) << clk_ctl_pkg::BIT_MAIN_SRC);
    wire [31:0] rd_proc = (32'(cfg_ff.div) << clk_ctl_pkg::DIV_LSB) |
                          (32'(cfg_ff.cpu_src) << clk_ctl_pkg::BIT_CPU_SRC) |
                          (32'(cfg_ff.cpu_src) << clk_ctl_pkg::BIT_CPU_ON_SUB);
    wire [31:0] rd_port = (32'(cfg_ff.port_out) << clk_ctl_pkg::PORT_OUT_LSB) |
                          (32'(cfg_ff.port_dir) << clk_ctl_pkg::PORT_DIR_LSB) |
                          (32'({b_sync_ff[1], a_sync_ff[1]}) << clk_ctl_pkg::PORT_IN_LSB);
    wire [31:0] rd_word =
        (ra == clk_ctl_pkg::OFS_PIN_CTRL)  ? rd_pin :
        (ra == clk_ctl_pkg::OFS_OSC_CTRL)  ? 32'(cfg_ff.hs_stop) << clk_ctl_pkg::BIT_HS_STOP :
        (ra == clk_ctl_pkg::OFS_MAIN_MODE) ? rd_mode :
        (ra == clk_ctl_pkg::OFS_PROC_CLK)  ? rd_proc :
        (ra == clk_ctl_pkg::OFS_PORT)      ? rd_port : 32'h0;

    // axi handshakes: one write and one read outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff} <= 4'h0;
            {awready_ff, wready_ff, arready_ff} <= 3'h7;
            aw_addr_ff <= '0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            bresp_ff   <= clk_ctl_pkg::RESP_OKAY;
            rresp_ff   <= clk_ctl_pkg::RESP_OKAY;
            rdata_ff   <= 32'h0;
        end else begin
            if (aw_hs) begin
                aw_addr_ff <= awaddr;
                aw_full_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (w_hs) begin
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
                w_full_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (do_wr) begin
                {aw_full_ff, w_full_ff} <= 2'h0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? clk_ctl_pkg::RESP_OKAY : clk_ctl_pkg::RESP_SLVERR;
            end
            if (b_done) begin
                bvalid_ff <= 1'b0;
                {awready_ff, wready_ff} <= 2'h3;
            end
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= rd_word;
                rresp_ff   <= rd_hit ? clk_ctl_pkg::RESP_OKAY : clk_ctl_pkg::RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    assign {awready, wready, bvalid, bresp} = {awready_ff, wready_ff, bvalid_ff, bresp_ff};
    assign {arready, rvalid, rdata, rresp}  = {arready_ff, rvalid_ff, rdata_ff, rresp_ff};
    assign {pin_a_out, pin_a_oe, pin_b_out, pin_b_oe} = {a_out_ff, a_oe_ff, b_out_ff, b_oe_ff};
    assign {osc_amp_en, osc_high_gain, standby, cpu_hold} = {amp_ff, cfg_ff.gain, standby_ff, hold_ff};
    assign {main_clk_tick, periph_clk_tick} = {main_tick_ff, periph_tick_ff};

    // checks
    localparam int XTAL_M1 = int'(clk_ctl_pkg::XTAL_SUSP_CYC) - 1;
    logic [8:0] ext_seen_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || state_ff != clk_ctl_pkg::SUSP_EXT)
            ext_seen_ff <= 9'h0;
        else if (b_rise)
            ext_seen_ff <= ext_seen_ff + 9'h1;
    end

    property p_gain_once;
        @(posedge aclk) disable iff (!aresetn) gain_lock_ff |=> $stable(cfg_ff.gain);
    endproperty
    a_gain_once: assert property (p_gain_once) else $error("gain changed twice");

    sequence s_xtal_stop;
        hold_ff throughout ##XTAL_M1 1;
    endsequence
    property p_xtal_susp;
        @(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == clk_ctl_pkg::SUSP_XTAL) |-> s_xtal_stop ##1 !hold_ff;
    endproperty
    a_xtal_susp: assert property (p_xtal_susp) else $error("crystal stop length wrong");

    property p_ext_susp;
        @(posedge aclk) disable iff (!aresetn)
        $fell(state_ff == clk_ctl_pkg::SUSP_EXT) |-> $past(ext_seen_ff) == 9'(159);
    endproperty
    a_ext_susp: assert property (p_ext_susp) else $error("external stop length wrong");

    property p_xtal_pins;
        @(posedge aclk) disable iff (!aresetn) xtal_mode |=> !pin_a_oe && !pin_b_oe;
    endproperty
    a_xtal_pins: assert property (p_xtal_pins) else $error("pin driven in crystal mode");

    property p_ext_pins;
        @(posedge aclk) disable iff (!aresetn)
        ext_mode |=> !pin_b_oe && pin_a_oe == $past(cfg_ff.port_dir[0]);
    endproperty
    a_ext_pins: assert property (p_ext_pins) else $error("pins wrong in external mode");

    property p_hs_halt;
        @(posedge aclk) disable iff (!aresetn)
        (cfg_ff.hs_stop || standby_ff) |-> !fin_tick ##1 !osc_amp_en;
    endproperty
    a_hs_halt: assert property (p_hs_halt) else $error("high-speed clock not halted");

    property p_main_hs;
        @(posedge aclk) disable iff (!aresetn)
        main_hs |=> main_clk_tick == $past(fin_tick) && periph_clk_tick == main_clk_tick;
    endproperty
    a_main_hs: assert property (p_main_hs) else $error("main or peripheral clock source wrong");

    property p_reset_state;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> cfg_ff.hs_stop && !cfg_ff.cpu_src && !cfg_ff.main_src && !cfg_ff.pin_mode;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

    property p_div_legal;
        @(posedge aclk) disable iff (!aresetn) cfg_ff.div <= clk_ctl_pkg::DIV_MAX;
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("prohibited divide code held");
endmodule // hs_clk_ctrl

//--- verif/hs_clk_src.sv
// behavioural crystal resonator and external clock source on the shared pins
module hs_clk_src (
    input  wire logic aclk,
    input  wire logic amp_en,
    input  wire logic ext_run,
    output logic      pin_a,
    output logic      pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_ff = 2'h0;
    initial {pin_a, pin_b} = 2'b00;
    // four-cycle period; a stopped resonator sits low so no stray edges reach the counter
    always @(posedge aclk) begin
        ph_ff <= ph_ff + 2'h1;
        pin_a <= amp_en & ph_ff[1];
        pin_b <= ext_run ? ph_ff[1] : (amp_en & ~ph_ff[1]);
    end
endmodule // hs_clk_src

//--- verif/high_speed_clock_source_control_test.sv
// self-checking bench of the high-speed clock control
module high_speed_clock_source_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, stop_exec = 1'b0, standby_exit = 1'b0, ext_run = 1'b0, pin_a_in, pin_b_in;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0]  bresp, rresp, rr;
    logic awready, wready, bvalid, arready, rvalid, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic osc_amp_en, osc_high_gain, main_clk_tick, periph_clk_tick, cpu_clk_tick, cpu_hold, standby;
    int fail_count = 0, cmp_count = 0, mt = 0, pt = 0, ct = 0, hc = 0;
    hs_clk_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .stop_exec,
        .standby_exit, .sub_clk_tick(1'b0), .pin_a_in, .pin_a_out, .pin_a_oe, .pin_b_in, .pin_b_out,
        .pin_b_oe, .osc_amp_en, .osc_high_gain, .main_clk_tick, .periph_clk_tick, .cpu_clk_tick, .cpu_hold,
        .standby);
    hs_clk_src src (.aclk, .amp_en(osc_amp_en), .ext_run, .pin_a(pin_a_in), .pin_b(pin_b_in));
    initial forever #25 aclk = ~aclk;
    // tick and hold counters, cleared between edges so they never race the edge updates
    always @(posedge aclk) begin
        if (main_clk_tick) mt <= mt + 1;
        if (periph_clk_tick) pt <= pt + 1;
        if (cpu_clk_tick) ct <= ct + 1;
        if (cpu_hold) hc <= hc + 1;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rng(input string n, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic rst;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic clr;
        @(negedge aclk);
        {mt, pt, ct, hc} = '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // one-cycle strobe: stop instruction, or standby exit when ex is set
    task automatic pulse(input bit ex);
        @(posedge aclk);
        if (ex) standby_exit <= 1'b1;
        else stop_exec <= 1'b1;
        @(posedge aclk);
        {stop_exec, standby_exit} <= 2'b00;
        repeat (3) @(posedge aclk);
    endtask
    // wait out the cpu hold after a gain raise, bounded
    task automatic gain_hold(input logic [31:0] d);
        clr();
        wr(8'h00, d);
        for (int i = 0; i < 900 && (cpu_hold || hc == 0); i++) @(posedge aclk);
    endtask
    task automatic t_reset;
        chk("pin oe", 32'h0, {pin_a_oe, pin_b_oe});
        rd(8'h04);
        chk("osc ctrl", 32'h80, rv);
        rd(8'h08);
        chk("main mode", 32'h0, rv);
        rd(8'h14);
        chk("unmapped resp", 32'h2, rr);
        wr(8'h14, 32'h0);
        chk("unmapped bresp", 32'h2, rr);
        $display("reset test end");
    endtask
    task automatic t_xtal;
        wr(8'h00, 32'h40);
        wr(8'h04, 32'h0);
        clr();
        chk("amp on", 32'h1, {pin_b_oe, pin_a_oe, osc_amp_en});
        // cpu stays on the internal clock while the crystal would settle
        repeat (20) @(posedge aclk);
        #1 rng("cpu ticks settling", 9, 11, ct);
        gain_hold(32'h41);
        rng("xtal hold", 82, 82, hc);
        chk("high gain", 32'h1, osc_high_gain);
        wr(8'h00, 32'h40);
        rd(8'h00);
        chk("gain locked", 32'h41, rv);
        pulse(1'b0);
        chk("standby", 32'h2, {standby, osc_amp_en});
        pulse(1'b1);
        wr(8'h04, 32'h80);
        @(negedge aclk);
        chk("amp off", 32'h0, osc_amp_en);
        $display("crystal test end");
    endtask
    task automatic t_ext;
        @(posedge aclk);
        rst();
        wr(8'h00, 32'hc0);
        ext_run <= 1'b1;
        wr(8'h04, 32'h0);
        wr(8'h10, 32'hf);
        @(negedge aclk);
        chk("ext pins", 32'hb, {pin_b_out, pin_b_oe, pin_a_out, pin_a_oe});
        gain_hold(32'hc1);
        rng("ext hold", 632, 648, hc);
        for (int s = 4; s < 6; s++) begin
            wr(8'h08, 32'(s));
            clr();
            repeat (40) @(posedge aclk);
            #1 rng("main ticks", s == 4 ? 39 : 9, s == 4 ? 40 : 11, mt);
            rng("periph ticks", 9, 11, pt);
        end
        rd(8'h08);
        chk("cpu on hs", 32'h7, rv);
        wr(8'h08, 32'h0);
        for (int c = 0; c < 6; c++) begin
            wr(8'h0c, 32'(c));
            clr();
            repeat (64) @(posedge aclk);
            // code 5 is refused, so the ratio stays at sixteen
            #1 rng("cpu ticks", (64 >> (c > 4 ? 4 : c)) - 1, (64 >> (c > 4 ? 4 : c)) + 1, ct);
        end
        rd(8'h0c);
        chk("div code", 32'h4, rv);
        // subsystem tick is tied low, so the cpu must see no tick at all
        wr(8'h0c, 32'h14);
        clr();
        rd(8'h0c);
        chk("cpu on sub", 32'h34, rv);
        chk("sub ticks", 32'h0, ct);
        $display("external test end");
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        test_done();
    end
    initial begin
        rst();
        t_reset();
        t_xtal();
        t_ext();
        test_done();
    end
endmodule // high_speed_clock_source_control_test
